// ==== hdl/jtag_prog_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module jtag_prog_port #(
	parameter logic [jtag_prog_pkg::TOUT_W-1:0] TOUT_FAST = jtag_prog_pkg::TOUT_FAST_DEF,
	parameter logic [jtag_prog_pkg::TOUT_W-1:0] TOUT_SLOW = jtag_prog_pkg::TOUT_SLOW_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Test port pins
	input wire jtag_prog_pkg::tap_pins_s pins,
	output logic tdo,
	output logic tdoEn,
	// Core reset
	input wire logic slowTimeoutFuse,
	output logic coreResetn,
	// Memory programming logic
	input wire logic [jtag_prog_pkg::CMD_W-1:0] cmdResult,
	output logic [jtag_prog_pkg::CMD_W-1:0] cmdOut,
	output logic cmdExec,
	output logic progEnabled,
	output jtag_prog_pkg::page_wr_s pageWr,
	output logic [jtag_prog_pkg::BADDR_W-1:0] pageRdAddr,
	input wire logic [7:0] pageRdData
);
	import jtag_prog_pkg::*;

	// ----------------------------------------
	// Pin synchronisers and TCK edges
	// ----------------------------------------
	tap_pins_s pinsS1_q, pinsS2_q;
	logic tckPrev_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinsS1_q <= '0;
			pinsS2_q <= '0;
			tckPrev_q <= 1'b0;
		end else begin
			pinsS1_q <= pins;
			pinsS2_q <= pinsS1_q;
			tckPrev_q <= pinsS2_q.tck;
		end
	end
	logic tckRise, tckFall;
	assign tckRise = pinsS2_q.tck & ~tckPrev_q;
	assign tckFall = ~pinsS2_q.tck & tckPrev_q;

	// ----------------------------------------
	// TAP controller
	// ----------------------------------------
	function automatic tap_state_e tapNext(input tap_state_e s, input logic m);
		unique case (s)
			TLR: return m ? TLR : RTI;
			RTI: return m ? SEL_DR : RTI;
			SEL_DR: return m ? SEL_IR : CAP_DR;
			CAP_DR: return m ? EX1_DR : SH_DR;
			SH_DR: return m ? EX1_DR : SH_DR;
			EX1_DR: return m ? UPD_DR : PAU_DR;
			PAU_DR: return m ? EX2_DR : PAU_DR;
			EX2_DR: return m ? UPD_DR : SH_DR;
			UPD_DR: return m ? SEL_DR : RTI;
			SEL_IR: return m ? TLR : CAP_IR;
			CAP_IR: return m ? EX1_IR : SH_IR;
			SH_IR: return m ? EX1_IR : SH_IR;
			EX1_IR: return m ? UPD_IR : PAU_IR;
			PAU_IR: return m ? EX2_IR : PAU_IR;
			EX2_IR: return m ? UPD_IR : SH_IR;
			UPD_IR: return m ? SEL_DR : RTI;
		endcase
	endfunction

	tap_state_e tap_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) tap_q <= TLR;
		else if (tckRise) tap_q <= tapNext(tap_q, pinsS2_q.tms);
	end

	logic tdi;
	assign tdi = pinsS2_q.tdi;
	logic capDr, shDr, updDr;
	assign capDr = tckRise && tap_q == CAP_DR;
	assign shDr = tckRise && tap_q == SH_DR;
	assign updDr = tckRise && tap_q == UPD_DR;

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	logic [IR_W-1:0] irSh_q, ir_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irSh_q <= '0;
			ir_q <= '1;
		end else if (tckRise) begin
			unique case (tap_q)
				TLR: ir_q <= '1;
				CAP_IR: irSh_q <= IR_CAPTURE;
				SH_IR: irSh_q <= {tdi, irSh_q[IR_W-1:1]};
				UPD_IR: ir_q <= irSh_q;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// Reset chain and time-out
	// ----------------------------------------
	logic rstBit_q, bypass_q;
	logic rstBitD;
	assign rstBitD = (shDr && ir_q == OP_RESET) ? tdi : rstBit_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstBit_q <= 1'b0;
			bypass_q <= 1'b0;
		end else begin
			rstBit_q <= rstBitD;
			if (capDr) bypass_q <= 1'b0;
			else if (shDr) bypass_q <= tdi;
		end
	end

	logic [TOUT_W-1:0] tout_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) tout_q <= '0;
		else if (rstBitD) tout_q <= slowTimeoutFuse ? TOUT_SLOW : TOUT_FAST;
		else if (tout_q != '0) tout_q <= tout_q - 1'b1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) coreResetn <= 1'b0;
		else coreResetn <= !rstBitD && (tout_q <= TOUT_W'(1));
	end

	// ----------------------------------------
	// Unlock register
	// ----------------------------------------
	logic [UNLOCK_W-1:0] unlock_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unlock_q <= UNLOCK_RST;
			progEnabled <= 1'b0;
		end else begin
			if (shDr && ir_q == OP_UNLOCK) unlock_q <= {tdi, unlock_q[UNLOCK_W-1:1]};
			if (updDr && ir_q == OP_UNLOCK) progEnabled <= unlock_q == UNLOCK_SIG;
		end
	end

	// ----------------------------------------
	// Command register
	// ----------------------------------------
	logic [CMD_W-1:0] cmdSh_q;
	logic cmdPending_q;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmdSh_q <= '0;
			cmdOut <= '0;
			cmdExec <= 1'b0;
			cmdPending_q <= 1'b0;
		end else begin
			cmdExec <= 1'b0;
			if (ir_q == OP_CMD) begin
				if (capDr) cmdSh_q <= cmdResult;
				if (shDr) cmdSh_q <= {tdi, cmdSh_q[CMD_W-1:1]};
				if (updDr && progEnabled) begin
					cmdOut <= cmdSh_q;
					cmdPending_q <= 1'b1;
				end
				if (tckRise && tap_q == RTI && cmdPending_q && progEnabled)
					cmdExec <= 1'b1;
			end
			if (tckRise && tap_q == SEL_DR) cmdPending_q <= cmdPending_q && ir_q == OP_CMD;
		end
	end

	// ----------------------------------------
	// Virtual page load and page read chains
	// ----------------------------------------
	logic [7:0] pageSh_q;
	logic [2:0] bitCnt_q;
	logic [BADDR_W:0] byteCnt_q;
	logic isLoad, isRead;
	assign isLoad = ir_q == OP_PLOAD;
	assign isRead = ir_q == OP_PREAD;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pageSh_q <= '0;
			bitCnt_q <= '0;
			byteCnt_q <= '0;
			pageWr <= '0;
			pageRdAddr <= '0;
		end else begin
			pageWr.en <= 1'b0;
			if (capDr && (isLoad || isRead)) begin
				bitCnt_q <= '0;
				byteCnt_q <= '0;
				pageRdAddr <= '0;
			end else if (shDr && isLoad) begin
				pageSh_q <= {tdi, pageSh_q[7:1]};
				bitCnt_q <= bitCnt_q + 1'b1;
				if (bitCnt_q == 3'h7 && !byteCnt_q[BADDR_W]) begin
					pageWr.en <= progEnabled;
					pageWr.addr <= byteCnt_q[BADDR_W-1:0];
					pageWr.data <= {tdi, pageSh_q[7:1]};
					byteCnt_q <= byteCnt_q + 1'b1;
				end
			end else if (shDr && isRead) begin
				bitCnt_q <= bitCnt_q + 1'b1;
				if (bitCnt_q == 3'h7 && !byteCnt_q[BADDR_W]) begin
					pageSh_q <= progEnabled ? pageRdData : 8'h00;
					pageRdAddr <= byteCnt_q[BADDR_W-1:0] + 1'b1;
					byteCnt_q <= byteCnt_q + 1'b1;
				end else begin
					pageSh_q <= {1'b0, pageSh_q[7:1]};
				end
			end
		end
	end

	// ----------------------------------------
	// TDO on falling TCK
	// ----------------------------------------
	logic drBit;
	always_comb begin
		unique case (ir_q)
			OP_RESET: drBit = rstBit_q;
			OP_UNLOCK: drBit = unlock_q[0];
			OP_CMD: drBit = cmdSh_q[0];
			OP_PLOAD, OP_PREAD: drBit = pageSh_q[0];
			default: drBit = bypass_q;
		endcase
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tdo <= 1'b0;
			tdoEn <= 1'b0;
		end else if (tckFall) begin
			tdo <= tap_q == SH_IR ? irSh_q[0] : drBit;
			tdoEn <= tap_q == SH_IR || tap_q == SH_DR;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence sUnlockUpd;
		updDr && ir_q == OP_UNLOCK;
	endsequence
	sequence sCmdUpd;
		updDr && ir_q == OP_CMD && progEnabled;
	endsequence

	a_reset_follows_bit: assert property (@(posedge clk) disable iff (!resetn)
		rstBitD |=> !coreResetn) else $error("core reset not asserted by reset bit");
	a_timeout_holds_reset: assert property (@(posedge clk) disable iff (!resetn)
		$fell(rstBit_q) |-> !coreResetn [*2]) else $error("reset released before time-out");
	a_unlock_match: assert property (@(posedge clk) disable iff (!resetn)
		sUnlockUpd |=> progEnabled == ($past(unlock_q) == UNLOCK_SIG))
		else $error("unlock compare wrong");
	a_cmd_update: assert property (@(posedge clk) disable iff (!resetn)
		sCmdUpd |=> cmdOut == $past(cmdSh_q)) else $error("command not applied");
	a_cmd_capture: assert property (@(posedge clk) disable iff (!resetn)
		capDr && ir_q == OP_CMD |=> cmdSh_q == $past(cmdResult)) else $error("result not captured");
	a_cmd_shift: assert property (@(posedge clk) disable iff (!resetn)
		shDr && ir_q == OP_CMD |=> cmdSh_q[CMD_W-1] == $past(tdi)) else $error("command shift wrong");
	a_exec_cause: assert property (@(posedge clk) disable iff (!resetn)
		cmdExec |-> $past(tap_q) == RTI && progEnabled) else $error("stray execute pulse");
	a_locked_no_write: assert property (@(posedge clk) disable iff (!resetn)
		!progEnabled |=> !pageWr.en && !cmdExec) else $error("memory touched while locked");
	a_load_byte: assert property (@(posedge clk) disable iff (!resetn)
		pageWr.en |-> $past(shDr && isLoad && bitCnt_q == 3'h7)) else $error("bad page write");
	a_read_ignore_tdi: assert property (@(posedge clk) disable iff (!resetn)
		shDr && isRead && bitCnt_q != 3'h7 |=> pageSh_q[7] == 1'b0) else $error("tdi leaked");
endmodule
`default_nettype wire

// ==== shared/jtag_prog_pkg.sv ====
// Operation
// - Opcode 5 puts the 15-bit command register between TDI and TDO.
// - Capture-DR under opcode 5 loads the previous command's result.
// - Shift-DR under opcode 5 shifts result out, new command in.
// - Update-DR under opcode 5 drives the command to the memory logic.
// - Each TCK cycle in Run-Test/Idle after an update gives one execute cycle.
// - Opcode 6 selects a 1024-bit virtual chain over an 8-bit register.
// - Page load writes each finished byte to the page buffer in Shift-DR.
// - Opcode 7 selects a 1032-bit virtual chain over an 8-bit register.
// - Page read captures nothing; Shift-DR fetches bytes and shifts out.
// - TDI is ignored while shifting under page read.
// - A one in the reset register holds the core in reset.
// - Reset register acts unlatched; reset follows the bit while shifting.
// - After the reset bit clears, reset stays for a fuse-chosen time-out.
// - Programming is enabled only while unlock register equals the signature.
// - Unlock register clears on power-on reset; programmer clears on exit.
// - All shift registers move least significant bit first.
// - 4-bit instruction register; opcode C selects the reset bit only.
// - Opcode 4 shifts the unlock value; Update-DR compares it.
`default_nettype none
package jtag_prog_pkg;
	localparam int IR_W = 4;
	localparam int CMD_W = 15;
	localparam int UNLOCK_W = 16;
	localparam int PAGE_BYTES = 128;
	localparam int BADDR_W = 7;
	localparam logic [IR_W-1:0] OP_UNLOCK = 4'h4;
	localparam logic [IR_W-1:0] OP_CMD = 4'h5;
	localparam logic [IR_W-1:0] OP_PLOAD = 4'h6;
	localparam logic [IR_W-1:0] OP_PREAD = 4'h7;
	localparam logic [IR_W-1:0] OP_RESET = 4'hc;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	localparam logic [UNLOCK_W-1:0] UNLOCK_SIG = 16'ha370;
	localparam logic [UNLOCK_W-1:0] UNLOCK_RST = 16'h0000;
	localparam int TOUT_W = 20;
	localparam logic [TOUT_W-1:0] TOUT_FAST_DEF = 20'h00010;
	localparam logic [TOUT_W-1:0] TOUT_SLOW_DEF = 20'h10000;

	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
	} tap_state_e;

	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} tap_pins_s;

	typedef struct packed {
		logic en;
		logic [BADDR_W-1:0] addr;
		logic [7:0] data;
	} page_wr_s;
endpackage
`default_nettype wire

// ==== verif/jtag_prog_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module jtag_prog_host (
	// Clock and test port
	input wire logic clk,
	input wire logic tdo,
	input wire logic tdoEn,
	output var jtag_prog_pkg::tap_pins_s pins
);
	import jtag_prog_pkg::*;
	initial pins = '0;
	// ----------------------------------------
	// TCK cycles of 32 clk, still between frames
	// ----------------------------------------
	task automatic tick(input logic m, input logic d, output logic o);
		@(posedge clk);
		pins.tck <= 1'b0;
		pins.tms <= m;
		pins.tdi <= d;
		repeat (16) @(posedge clk);
		// Released TDO floats to its pull-up level
		o = tdoEn ? tdo : 1'b1;
		pins.tck <= 1'b1;
		repeat (15) @(posedge clk);
	endtask
	task automatic idle();
		logic o;
		repeat (5) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
	// Only device on the chain, so page instructions are allowed
	task automatic scan(input logic ir, input int n, input logic [1031:0] din,
			output logic [1031:0] dout);
		logic o;
		dout = '0;
		tick(1'b1, 1'b0, o);
		if (ir) tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
	endtask
endmodule
`default_nettype wire

// ==== verif/jtag_prog_port_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module jtag_prog_port_tb_top;
	import jtag_prog_pkg::*;
	localparam int FAST = 200;
	localparam int SLOW = 600;
	logic clk, resetn, slowTimeoutFuse, tdo, tdoEn, coreResetn, cmdExec, progEnabled, o;
	tap_pins_s pins;
	logic [CMD_W-1:0] cmdResult, cmdOut;
	page_wr_s pageWr;
	logic [BADDR_W-1:0] pageRdAddr;
	logic [7:0] pageRdData;
	logic [7:0] pm [PAGE_BYTES];
	logic [1031:0] din, dout;
	int errorCnt = 0, checks = 0, wrCnt = 0, execCnt = 0, cyc = 0;
	// ----------------------------------------
	// Harness
	// ----------------------------------------
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	jtag_prog_port #(.TOUT_FAST(20'(FAST)), .TOUT_SLOW(20'(SLOW))) uut (.clk(clk),
		.resetn(resetn), .pins(pins), .tdo(tdo), .tdoEn(tdoEn),
		.slowTimeoutFuse(slowTimeoutFuse), .coreResetn(coreResetn),
		.cmdResult(cmdResult), .cmdOut(cmdOut), .cmdExec(cmdExec),
		.progEnabled(progEnabled), .pageWr(pageWr), .pageRdAddr(pageRdAddr),
		.pageRdData(pageRdData));
	jtag_prog_host host (.clk(clk), .tdo(tdo), .tdoEn(tdoEn), .pins(pins));
	always @(posedge clk) begin
		pageRdData <= pm[pageRdAddr];
		if (pageWr.en === 1'b1) begin
			pm[pageWr.addr] <= pageWr.data;
			wrCnt++;
		end
		if (cmdExec === 1'b1) execCnt++;
		cyc++;
		if (cyc == 90000) begin
			errorCnt++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [7:0] pat(input int k);
		return 8'(k * 37 + 5);
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_bypass();
		host.scan(1'b1, 4, 1032'(4'hf), dout);
		chk("ir capture", dout[3:0], IR_CAPTURE);
		host.scan(1'b0, 2, 1032'(2'b11), dout);
		chk("bypass path", dout[1:0], 2'b10);
	endtask
	task automatic t_core_reset();
		int n, t;
		for (int f = 0; f < 2; f++) begin
			slowTimeoutFuse <= f[0];
			t = f ? SLOW : FAST;
			host.scan(1'b1, 4, 1032'(OP_RESET), dout);
			host.tick(1'b1, 1'b0, o);
			host.tick(1'b0, 1'b0, o);
			host.tick(1'b0, 1'b0, o);
			host.tick(1'b1, 1'b1, o);
			repeat (10) @(posedge clk);
			chk("reset before update", coreResetn, 1'b0);
			host.tick(1'b1, 1'b0, o);
			host.tick(1'b0, 1'b0, o);
			repeat (300) @(posedge clk);
			chk("reset held", coreResetn, 1'b0);
			host.scan(1'b0, 1, 1032'(0), dout);
			n = 0;
			while (coreResetn !== 1'b1 && n < 2000) begin
				@(posedge clk);
				n++;
			end
			chk("reset timeout", n > t - 100 && n < t - 40, 1'b1);
		end
	endtask
	task automatic t_unlock();
		host.scan(1'b1, 4, 1032'(OP_UNLOCK), dout);
		host.scan(1'b0, 16, 1032'(16'h5555), dout);
		chk("unlock wrong sig", progEnabled, 1'b0);
		host.scan(1'b1, 4, 1032'(OP_CMD), dout);
		host.scan(1'b0, 15, 1032'(15'h7fff), dout);
		chk("locked command", cmdOut, 15'h0);
		host.scan(1'b1, 4, 1032'(OP_PLOAD), dout);
		host.scan(1'b0, 16, '1, dout);
		chk("locked page load", wrCnt, 0);
		host.scan(1'b1, 4, 1032'(OP_UNLOCK), dout);
		host.scan(1'b0, 16, 1032'(UNLOCK_SIG), dout);
		chk("unlock sig", progEnabled, 1'b1);
	endtask
	task automatic t_command();
		int e0;
		@(posedge clk);
		cmdResult <= 15'h1b3c;
		host.scan(1'b1, 4, 1032'(OP_CMD), dout);
		e0 = execCnt;
		host.scan(1'b0, 15, 1032'(15'h2a55), dout);
		chk("cmd result out", dout[14:0], 15'h1b3c);
		chk("cmd applied", cmdOut, 15'h2a55);
		chk("tdo released", tdoEn, 1'b0);
		chk("no exec yet", execCnt - e0, 0);
		host.tick(1'b0, 1'b0, o);
		repeat (8) @(posedge clk);
		chk("one exec", execCnt - e0, 1);
	endtask
	task automatic t_page();
		int w0;
		for (int k = 0; k < PAGE_BYTES; k++) din[8*k+:8] = pat(k);
		w0 = wrCnt;
		host.scan(1'b1, 4, 1032'(OP_PLOAD), dout);
		host.scan(1'b0, 1024, din, dout);
		chk("page writes", wrCnt - w0, PAGE_BYTES);
		for (int k = 0; k < PAGE_BYTES; k++) chk("page byte", pm[k], pat(k));
		host.scan(1'b1, 4, 1032'(OP_PREAD), dout);
		host.scan(1'b0, 1032, '1, dout);
		for (int k = 0; k < PAGE_BYTES; k++) chk("read byte", dout[8+8*k+:8], pat(k));
		host.scan(1'b1, 4, 1032'(OP_UNLOCK), dout);
		host.scan(1'b0, 16, 1032'(0), dout);
		chk("lock on exit", progEnabled, 1'b0);
	endtask
	initial begin
		resetn = 1'b0;
		slowTimeoutFuse = 1'b0;
		cmdResult = '0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("unlock after por", progEnabled, 1'b0);
		host.idle();
		t_bypass();
		t_core_reset();
		t_unlock();
		t_command();
		t_page();
		final_report();
	end
endmodule
`default_nettype wire
